// ==== doc_pkg.sv ====
// Package: register map, field layout, timing and types of the digital output channel
`default_nettype none
package doc_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned CLK_NS      = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_NS     = 100_000;                  // 0.1 ms base unit
  localparam int unsigned TICK_CYC    = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [11:0] TICK_LAST   = 12'(TICK_CYC - 1);
  localparam logic [11:0] TICK_ZERO   = 12'h000;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [4:0]  ADDR_CTRL   = 5'h00;
  localparam logic [4:0]  ADDR_LOW    = 5'h04;
  localparam logic [4:0]  ADDR_HIGH   = 5'h08;
  localparam logic [4:0]  ADDR_TOTAL  = 5'h0C;
  localparam logic [4:0]  ADDR_DELAY  = 5'h10;
  localparam logic [4:0]  ADDR_CMD    = 5'h14;
  localparam logic [4:0]  ADDR_STATUS = 5'h18;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_FIXED    = 2;
  localparam int unsigned CTRL_LEVEL    = 3;
  localparam int unsigned CMD_APPLY     = 0;
  localparam int unsigned CMD_START     = 1;
  localparam int unsigned CMD_STOP      = 2;
  localparam int unsigned ST_LEVEL      = 0;
  localparam int unsigned ST_RUN        = 1;
  localparam int unsigned ST_MODE_LSB   = 2;
  localparam int unsigned ST_PEND       = 4;
  localparam int unsigned ST_COUNT_LSB  = 16;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int unsigned CNT_W   = 16;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_DIRECT = 2'b00,
    MODE_PULSE  = 2'b01,
    MODE_RISE   = 2'b10,   // delayed_rise_mode
    MODE_FALL   = 2'b11    // delayed_fall_mode
  } doc_mode_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b10
  } doc_phase_t;

  typedef struct packed {
    doc_mode_t        mode;
    logic             fixed;
    logic [CNT_W-1:0] low_w;
    logic [CNT_W-1:0] high_w;
    logic [CNT_W-1:0] total;
    logic [CNT_W-1:0] delay;
  } doc_cfg_t;

  localparam doc_cfg_t CFG_RESET = '{MODE_DIRECT, 1'b0, CNT_ZERO, CNT_ZERO, CNT_ZERO, CNT_ZERO};

endpackage : doc_pkg
`default_nettype wire

// ==== doc_channel.sv ====
// Digital output channel: direct, pulse and delayed-edge modes behind an Avalon-MM slave
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none
module doc_channel
  import doc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             dout_o
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Byte-lane merge for partial writes
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // True when a tick count has reached its limit; a limit of zero ends on first tick
  function automatic logic span_done(input logic [CNT_W-1:0] cnt,
                                     input logic [CNT_W-1:0] lim);
    return ({1'b0, cnt} + {1'b0, CNT_ONE}) >= {1'b0, lim};
  endfunction

  // Word select of a byte address; the two low bits never select anything
  function automatic logic reg_hit(input logic [4:0] addr,
                                   input logic [4:0] base);
    return addr[4:2] == base[4:2];
  endfunction

  // Zero-extend a 16-bit field to a bus word
  function automatic logic [31:0] field_word(input logic [CNT_W-1:0] v);
    return {16'h0000, v};
  endfunction

  // Counter step shared by the pulse and delay counters
  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] cnt);
    return cnt + CNT_ONE;
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  doc_cfg_t         stage_reg;      // Written by software, not yet in use
  doc_cfg_t         act_reg;        // Configuration in force
  logic             level_reg;      // Commanded output level

  // Bus handshake
  logic             wait_reg;
  logic [31:0]      rdata_reg;

  // Prescaler
  logic [11:0]      pre_reg;
  logic             tick_reg;

  // Pulse engine
  doc_phase_t       phase_reg;
  doc_phase_t       phase_next;
  logic [CNT_W-1:0] ph_cnt_reg;
  logic [CNT_W-1:0] ph_cnt_next;
  logic [CNT_W-1:0] pcnt_reg;
  logic [CNT_W-1:0] pcnt_next;

  // Delay counter and output
  logic [CNT_W-1:0] dly_cnt_reg;
  logic [CNT_W-1:0] dly_cnt_next;
  logic             out_reg;
  logic             out_next;

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  // One wait cycle per access: read data captured while waitrequest is high
  wire logic        req      = avs_read_i | avs_write_i;
  wire logic        rd_take  = avs_read_i & wait_reg;
  wire logic        wr_take  = avs_write_i & ~wait_reg;
  wire logic        sel_ctrl = reg_hit(avs_address_i, ADDR_CTRL);
  wire logic        sel_low  = reg_hit(avs_address_i, ADDR_LOW);
  wire logic        sel_high = reg_hit(avs_address_i, ADDR_HIGH);
  wire logic        sel_tot  = reg_hit(avs_address_i, ADDR_TOTAL);
  wire logic        sel_dly  = reg_hit(avs_address_i, ADDR_DELAY);
  wire logic        sel_cmd  = reg_hit(avs_address_i, ADDR_CMD);
  wire logic        sel_st   = reg_hit(avs_address_i, ADDR_STATUS);

  // Register views as words
  wire logic [31:0] ctrl_word = {28'h000_0000, level_reg, stage_reg.fixed, stage_reg.mode};
  wire logic [31:0] low_word  = field_word(stage_reg.low_w);
  wire logic [31:0] high_word = field_word(stage_reg.high_w);
  wire logic [31:0] tot_word  = field_word(stage_reg.total);
  wire logic [31:0] dly_word  = field_word(stage_reg.delay);

  // Merged write values
  wire logic [31:0] ctrl_wr = be_merge(ctrl_word, avs_writedata_i, avs_byteenable_i);
  wire logic [31:0] low_wr  = be_merge(low_word,  avs_writedata_i, avs_byteenable_i);
  wire logic [31:0] high_wr = be_merge(high_word, avs_writedata_i, avs_byteenable_i);
  wire logic [31:0] tot_wr  = be_merge(tot_word,  avs_writedata_i, avs_byteenable_i);
  wire logic [31:0] dly_wr  = be_merge(dly_word,  avs_writedata_i, avs_byteenable_i);
  wire logic [31:0] cmd_wr  = be_merge(WORD_ZERO, avs_writedata_i, avs_byteenable_i);

  // Command strobes, one cycle each
  wire logic        cmd_hit   = wr_take & sel_cmd;
  wire logic        do_apply  = cmd_hit & cmd_wr[CMD_APPLY];
  wire logic        do_stop   = cmd_hit & cmd_wr[CMD_STOP];
  wire logic        do_start  = cmd_hit & cmd_wr[CMD_START];

  // ==========================================================================
  // Status and read mux
  // ==========================================================================
  wire logic        running   = phase_reg != PH_IDLE;
  wire logic        pending;
  wire logic [31:0] st_word;
  assign st_word = (32'(out_reg) << ST_LEVEL)
                 | (32'(running) << ST_RUN)
                 | (32'(act_reg.mode) << ST_MODE_LSB)
                 | (32'(pending) << ST_PEND)
                 | (32'(pcnt_reg) << ST_COUNT_LSB);

  // Unmapped addresses and the command register read as zero
  wire logic [31:0] rd_word = sel_ctrl ? ctrl_word :
                              sel_low  ? low_word  :
                              sel_high ? high_word :
                              sel_tot  ? tot_word  :
                              sel_dly  ? dly_word  :
                              sel_st   ? st_word   : WORD_ZERO;

  // ==========================================================================
  // Avalon handshake
  // ==========================================================================
  // Waitrequest idles high so no access can slip through unanswered
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg  <= 1'b1;
      rdata_reg <= WORD_ZERO;
    end else begin
      wait_reg <= wait_reg ? ~req : 1'b1;
      if (rd_take) begin
        rdata_reg <= rd_word;
      end
    end
  end

  // ==========================================================================
  // Staged configuration and level command
  // ==========================================================================
  // Staged fields wait for apply so a half-written setup never runs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_reg <= CFG_RESET;
      level_reg <= 1'b0;
    end else if (wr_take) begin
      if (sel_ctrl) begin
        stage_reg.mode  <= doc_mode_t'(ctrl_wr[CTRL_MODE_LSB +: 2]);
        stage_reg.fixed <= ctrl_wr[CTRL_FIXED];
        level_reg       <= ctrl_wr[CTRL_LEVEL];
      end
      if (sel_low) begin
        stage_reg.low_w <= low_wr[CNT_W-1:0];
      end
      if (sel_high) begin
        stage_reg.high_w <= high_wr[CNT_W-1:0];
      end
      if (sel_tot) begin
        stage_reg.total <= tot_wr[CNT_W-1:0];
      end
      if (sel_dly) begin
        stage_reg.delay <= dly_wr[CNT_W-1:0];
      end
    end
  end

  // Apply copies the whole staged set into use
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_reg <= CFG_RESET;
    end else if (do_apply) begin
      act_reg <= stage_reg;
    end
  end

  // ==========================================================================
  // 0.1 ms prescaler
  // ==========================================================================
  // Wrap point of the prescaler, shared by the tick and the reload
  wire logic pre_wrap = pre_reg == TICK_LAST;

  // Free running: a start may see up to one tick of phase jitter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_reg  <= TICK_ZERO;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= pre_wrap;
      pre_reg  <= pre_wrap ? TICK_ZERO : pre_reg + 12'h001;
    end
  end

  // ==========================================================================
  // Pulse engine
  // ==========================================================================
  // A bounded run with a zero total has nothing to emit and never starts
  wire logic pulse_act = act_reg.mode == MODE_PULSE;
  wire logic start_go  = do_start & pulse_act & ~(act_reg.fixed & (act_reg.total == CNT_ZERO));
  wire logic halt      = do_stop | do_apply;
  wire logic [CNT_W-1:0] pcnt_inc = bump(pcnt_reg);

  // Each period is a low span followed by a high span
  always_comb begin
    phase_next  = phase_reg;
    ph_cnt_next = ph_cnt_reg;
    pcnt_next   = pcnt_reg;
    if (halt) begin
      phase_next = PH_IDLE;
    end else if (start_go) begin
      phase_next  = PH_LOW;
      ph_cnt_next = CNT_ZERO;
      pcnt_next   = CNT_ZERO;
    end else if (tick_reg) begin
      unique case (phase_reg)
        PH_IDLE: begin
          phase_next = PH_IDLE;
        end
        PH_LOW: begin
          if (span_done(ph_cnt_reg, act_reg.low_w)) begin
            phase_next  = PH_HIGH;
            ph_cnt_next = CNT_ZERO;
          end else begin
            ph_cnt_next = ph_cnt_reg + CNT_ONE;
          end
        end
        PH_HIGH: begin
          if (span_done(ph_cnt_reg, act_reg.high_w)) begin
            pcnt_next   = pcnt_inc;
            ph_cnt_next = CNT_ZERO;
            if (act_reg.fixed && pcnt_inc >= act_reg.total) begin
              phase_next = PH_IDLE;
            end else begin
              phase_next = PH_LOW;
            end
          end else begin
            ph_cnt_next = ph_cnt_reg + CNT_ONE;
          end
        end
        default: begin
          phase_next = PH_IDLE;
        end
      endcase
    end
  end

  // Pulse engine registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg  <= PH_IDLE;
      ph_cnt_reg <= CNT_ZERO;
      pcnt_reg   <= CNT_ZERO;
    end else begin
      phase_reg  <= phase_next;
      ph_cnt_reg <= ph_cnt_next;
      pcnt_reg   <= pcnt_next;
    end
  end

  // ==========================================================================
  // Delayed-edge logic and output
  // ==========================================================================
  // Only the guarded edge waits; the opposite edge passes at once
  wire logic rise_wait = (act_reg.mode == MODE_RISE) & level_reg & ~out_reg;
  wire logic fall_wait = (act_reg.mode == MODE_FALL) & ~level_reg & out_reg;
  assign pending = rise_wait | fall_wait;

  // Zero delay passes at once; otherwise the edge waits for its last tick
  wire logic dly_hit = (act_reg.delay == CNT_ZERO)
                     | (tick_reg & span_done(dly_cnt_reg, act_reg.delay));

  // Counter clears whenever nothing waits, which also cancels a pending edge
  always_comb begin
    dly_cnt_next = CNT_ZERO;
    if (pending && tick_reg) begin
      dly_cnt_next = bump(dly_cnt_reg);
    end else if (pending) begin
      dly_cnt_next = dly_cnt_reg;
    end
  end

  // Output selection per mode in force
  always_comb begin
    if (pending) begin
      out_next = dly_hit ? level_reg : out_reg;
    end else if (pulse_act) begin
      out_next = phase_reg == PH_HIGH;
    end else begin
      out_next = level_reg;
    end
  end

  // Delay counter and output flop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly_cnt_reg <= CNT_ZERO;
      out_reg     <= 1'b0;
    end else begin
      dly_cnt_reg <= dly_cnt_next;
      out_reg     <= out_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Every output comes straight from a flop
  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign dout_o            = out_reg;

endmodule : doc_channel // doc_channel
`default_nettype wire

// ==== doc_channel_asserts.sv ====
// Checker: port-level properties of the digital output channel
`timescale 1ns/10ps
`default_nettype none
module doc_channel_asserts
  import doc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_readdata_o,
  input  wire logic        avs_waitrequest_o,
  input  wire logic        dout_o
);
  // ==========================================================================
  // Shadow state; assumes full byte enables, as the bench always sends
  // ==========================================================================
  doc_cfg_t         stg_reg;
  doc_cfg_t         cfg_reg;
  logic             lvl_reg;
  logic             run_reg;
  logic [31:0]      since_reg;
  logic [31:0]      hi_reg;
  logic [15:0]      np_reg;
  wire logic        wr_w     = avs_write_i && !avs_waitrequest_o;
  wire logic        cmd_w    = wr_w && avs_address_i == ADDR_CMD;
  wire logic        ctl_w    = wr_w && avs_address_i == ADDR_CTRL;
  wire logic [15:0] d_w      = avs_writedata_i[15:0];
  wire logic [31:0] hi_exp_w = (cfg_reg.high_w == CNT_ZERO ? 32'h0000_0001 : 32'(cfg_reg.high_w)) * TICK_CYC;

  // Staged and applied settings follow the taken writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stg_reg <= CFG_RESET;
      cfg_reg <= CFG_RESET;
      lvl_reg <= 1'b0;
      run_reg <= 1'b0;
    end else if (wr_w) begin
      case (avs_address_i)
        ADDR_CTRL: begin
          stg_reg.mode  <= doc_mode_t'(avs_writedata_i[1:0]);
          stg_reg.fixed <= avs_writedata_i[CTRL_FIXED];
          lvl_reg       <= avs_writedata_i[CTRL_LEVEL];
        end
        ADDR_LOW:   stg_reg.low_w  <= d_w;
        ADDR_HIGH:  stg_reg.high_w <= d_w;
        ADDR_TOTAL: stg_reg.total  <= d_w;
        ADDR_DELAY: stg_reg.delay  <= d_w;
        ADDR_CMD: begin
          if (avs_writedata_i[CMD_APPLY]) cfg_reg <= stg_reg;
          run_reg <= !avs_writedata_i[CMD_APPLY] && !avs_writedata_i[CMD_STOP]
                     && (run_reg || avs_writedata_i[CMD_START]);
        end
        default: ;
      endcase
    end
  end

  // Level age, high span and pulses since start; age restarts only on a real change
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      since_reg <= WORD_ZERO;
      hi_reg    <= WORD_ZERO;
      np_reg    <= CNT_ZERO;
    end else begin
      since_reg <= (ctl_w && avs_writedata_i[CTRL_LEVEL] != lvl_reg) ? WORD_ZERO : since_reg + 32'h0000_0001;
      hi_reg    <= dout_o ? hi_reg + 32'h0000_0001 : WORD_ZERO;
      np_reg    <= (cmd_w && avs_writedata_i[CMD_START]) ? CNT_ZERO
                   : np_reg + 16'((!dout_o && hi_reg != WORD_ZERO) ? 1 : 0);
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_stop;
    cmd_w && avs_writedata_i[CMD_STOP] && cfg_reg.mode == MODE_PULSE;
  endsequence

  property p_wait_one;
    s_req |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  property p_status;
    avs_read_i && !avs_waitrequest_o && avs_address_i == ADDR_STATUS
      |-> avs_readdata_o[ST_LEVEL] == $past(dout_o) && avs_readdata_o[ST_MODE_LSB +: 2] == cfg_reg.mode;
  endproperty
  property p_direct;
    cfg_reg.mode == MODE_DIRECT && $changed(lvl_reg) |=> dout_o == lvl_reg;
  endproperty
  property p_rise_late;
    cfg_reg.mode == MODE_RISE && cfg_reg.delay != CNT_ZERO && $rose(dout_o)
      |-> since_reg >= (32'(cfg_reg.delay) - 32'h0000_0001) * TICK_CYC;
  endproperty
  property p_fall_late;
    cfg_reg.mode == MODE_FALL && cfg_reg.delay != CNT_ZERO && $fell(dout_o)
      |-> since_reg >= (32'(cfg_reg.delay) - 32'h0000_0001) * TICK_CYC;
  endproperty
  property p_rise_fast_fall;
    cfg_reg.mode == MODE_RISE && $fell(lvl_reg) |=> !dout_o;
  endproperty
  property p_fall_fast_rise;
    cfg_reg.mode == MODE_FALL && $rose(lvl_reg) |=> dout_o;
  endproperty
  property p_high_width;
    cfg_reg.mode == MODE_PULSE && run_reg && $fell(dout_o) |-> hi_reg == hi_exp_w;
  endproperty
  property p_total;
    cfg_reg.mode == MODE_PULSE && cfg_reg.fixed && $rose(dout_o) |-> np_reg < cfg_reg.total;
  endproperty
  property p_stop;
    s_stop |-> ##2 !dout_o [*8];
  endproperty

  a_wait_one:       assert property (p_wait_one)       else $error("wait state not exactly one cycle");
  a_status:         assert property (p_status)         else $error("status level or mode wrong");
  a_direct:         assert property (p_direct)         else $error("direct output not following level");
  a_rise_late:      assert property (p_rise_late)      else $error("rise came before the delay");
  a_fall_late:      assert property (p_fall_late)      else $error("fall came before the delay");
  a_rise_fast_fall: assert property (p_rise_fast_fall) else $error("fall delayed in rise mode");
  a_fall_fast_rise: assert property (p_fall_fast_rise) else $error("rise delayed in fall mode");
  a_high_width:     assert property (p_high_width)     else $error("high span length wrong");
  a_total:          assert property (p_total)          else $error("pulse beyond the total");
  a_stop:           assert property (p_stop)           else $error("output not low after stop");
endmodule // doc_channel_asserts

bind doc_channel doc_channel_asserts u_asserts (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .dout_o);
`default_nettype wire

// ==== doc_load.sv ====
// Partner: external load that counts the pulses it sees on the channel output
`timescale 1ns/10ps
`default_nettype none
module doc_load (
  input  wire logic        clk_i,
  input  wire logic        clr_i,
  input  wire logic        dout_i,
  output logic      [15:0] rise_cnt_o
);
  logic prev_reg;

  // Sink only: the load never drives the pin back
  always_ff @(posedge clk_i) begin
    prev_reg <= dout_i;
    if (clr_i)
      rise_cnt_o <= 16'h0000;
    else if (dout_i && !prev_reg)
      rise_cnt_o <= rise_cnt_o + 16'h0001;
  end
endmodule // doc_load
`default_nettype wire

// ==== doc_channel_tb.sv ====
// Testbench: bus-driven scenarios for the digital output channel
`timescale 1ns/10ps
`default_nettype none
module doc_channel_tb
  import doc_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = WORD_ZERO;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        dout_o;
  logic        clr = 1'b1;
  logic [15:0] rises;
  logic [31:0] q;
  int          num_errors = 0;
  int          n_compared = 0;

  doc_channel dut_u (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .dout_o);
  doc_load load_u (.clk_i, .clr_i(clr), .dout_i(dout_o), .rise_cnt_o(rises));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic finish_test();
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle held until waitrequest is sampled low; bounded wait
  task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    avs_read_i      <= rd;
    avs_write_i     <= !rd;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      finish_test();
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b1, a, WORD_ZERO);
    chk(q & m, e);
  endtask

  task automatic pin_after(input int n, input logic e);
    repeat (n) @(posedge clk_i);
    chk(32'(dout_o), 32'(e));
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    rd_chk(ADDR_STATUS, 32'hFFFF_FFFF, WORD_ZERO);
    rd_chk(5'h1C, 32'hFFFF_FFFF, WORD_ZERO);
    rd_chk(ADDR_CMD, 32'hFFFF_FFFF, WORD_ZERO);
  endtask

  task automatic t_direct();
    bus(1'b0, ADDR_CTRL, 32'h0000_000A);
    pin_after(3, 1'b1);
    rd_chk(ADDR_STATUS, 32'h0000_001F, 32'h0000_0001);
    bus(1'b0, ADDR_CTRL, 32'h0000_0002);
    pin_after(3, 1'b0);
  endtask

  task automatic t_rise();
    bus(1'b0, ADDR_DELAY, 32'h0000_0002);
    bus(1'b0, ADDR_CMD, 32'h0000_0001);
    rd_chk(ADDR_STATUS, 32'h0000_000C, 32'h0000_0008);
    bus(1'b0, ADDR_CTRL, 32'h0000_000A);
    rd_chk(ADDR_STATUS, 32'h0000_0011, 32'h0000_0010);
    pin_after(5010, 1'b1);
    bus(1'b0, ADDR_CTRL, 32'h0000_0002);
    pin_after(3, 1'b0);
    bus(1'b0, ADDR_CTRL, 32'h0000_000A);
    repeat (100) @(posedge clk_i);
    bus(1'b0, ADDR_CTRL, 32'h0000_0002);
    pin_after(5100, 1'b0);
  endtask

  task automatic t_fall();
    bus(1'b0, ADDR_CTRL, 32'h0000_0003);
    bus(1'b0, ADDR_CMD, 32'h0000_0001);
    bus(1'b0, ADDR_CTRL, 32'h0000_000B);
    pin_after(3, 1'b1);
    bus(1'b0, ADDR_CTRL, 32'h0000_0003);
    pin_after(3, 1'b1);
    pin_after(5010, 1'b0);
  endtask

  task automatic t_pulse(input logic fixed);
    int n;
    logic [15:0] held;
    bus(1'b0, ADDR_LOW, 32'h0000_0001);
    bus(1'b0, ADDR_HIGH, 32'h0000_0002);
    bus(1'b0, ADDR_TOTAL, 32'h0000_0003);
    bus(1'b0, ADDR_CTRL, {29'h0, fixed, 2'b01});
    bus(1'b0, ADDR_CMD, 32'h0000_0001);
    clr <= 1'b0;
    bus(1'b0, ADDR_CMD, 32'h0000_0002);
    if (fixed) begin
      for (n = 0; n < 40; n++) begin
        repeat (1000) @(posedge clk_i);
        bus(1'b1, ADDR_STATUS, WORD_ZERO);
        if (q[ST_RUN] === 1'b0) break;
      end
      // Run never ended: out of time
      if (n == 40) begin
        num_errors++;
        finish_test();
      end
      chk(32'(rises), 32'h0000_0003);
      rd_chk(ADDR_STATUS, 32'hFFFF_0003, 32'h0003_0000);
    end else begin
      repeat (28000) @(posedge clk_i);
      chk(32'(rises > 16'h0003), 32'h0000_0001);
      bus(1'b0, ADDR_CMD, 32'h0000_0004);
      // Let a rise launched at the stop edge reach the load first
      repeat (2) @(posedge clk_i);
      held = rises;
      pin_after(8000, 1'b0);
      chk(32'(rises), 32'(held));
    end
    clr <= 1'b1;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_direct();
    t_rise();
    t_fall();
    t_pulse(1'b1);
    t_pulse(1'b0);
    finish_test();
  end
endmodule // doc_channel_tb
`default_nettype wire
